// [hdl/lcpm_consts.svh]
`ifndef LCPM_CONSTS_SVH
`define LCPM_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define LCPM_IDX_LINK_CAP2 8'h6C
`define LCPM_IDX_LINK_CTL2 8'h70
`define LCPM_IDX_LINK_STS2 8'h72
`define LCPM_IDX_SLOT_CAP2 8'h74
`define LCPM_IDX_SLOT_CTL2 8'h78
`define LCPM_IDX_SLOT_STS2 8'h7A
`define LCPM_IDX_PM_CAP 8'hC0

// Link control two fields.
`define LCPM_TLS_LSB 0
`define LCPM_TLS_MSB 3
`define LCPM_ENTER_COMPLIANCE_BIT_BIT 4
`define LCPM_AUTONOMOUS_SPEED_INHIBIT_BIT 5
`define LCPM_TLS_RST 4'h0
`define LCPM_TLS_GEN1 4'h1
`define LCPM_TLS_GEN2 4'h2

// Power management capability fields and values.
`define LCPM_CAPABILITY_IDENTIFIER_VAL 8'h01
`define LCPM_NXT_UP 8'h00
`define LCPM_NXT_DOWN 8'hD0
`define LCPM_VER_VAL 3'h3
`define LCPM_WAKECLK_VAL 1'h0
`define LCPM_SPECIAL_INIT_FLAG_RST 1'h0
`define LCPM_AUX_VAL 3'h0
`define LCPM_D1_VAL 1'h0
`define LCPM_D2_VAL 1'h0
`define LCPM_PME_RST 5'h19
`define LCPM_SPECIAL_INIT_FLAG_BIT 21
`define LCPM_PME_LSB 27

`endif

// [hdl/lcpm_pkg.sv]
package lcpm_pkg;

    typedef enum logic [1:0] {
        LCPM_SPD_NONE,
        LCPM_SPD_2G5,
        LCPM_SPD_5G0
    } lcpm_speed_t;

    typedef enum logic {
        LCPM_APB_IDLE,
        LCPM_APB_ANSWER
    } lcpm_apb_state_t;

endpackage

// [hdl/lcpm_speed_ctl.sv]
`timescale 1ns/1ps
`include "lcpm_consts.svh"

module lcpm_speed_ctl #(
    parameter lcpm_pkg::lcpm_speed_t MAX_SPEED = lcpm_pkg::LCPM_SPD_2G5
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_downstream,
    input wire logic [3:0] i_tls,
    input wire logic i_enter_compliance_bit,
    input wire logic i_autonomous_speed_inhibit,
    input wire logic i_d3cold,
    input wire logic i_pme_msg_in,
    input wire logic i_auto_change_req,
    input wire logic i_downshift_req,
    output lcpm_pkg::lcpm_speed_t o_adv_speed,
    output lcpm_pkg::lcpm_speed_t o_compliance_speed,
    output logic o_enter_compliance,
    output logic o_speed_change_grant,
    output logic o_pme_fwd
);

    function automatic lcpm_pkg::lcpm_speed_t decode_speed(input logic [3:0] code);
        case (code)
            `LCPM_TLS_GEN1: decode_speed = lcpm_pkg::LCPM_SPD_2G5;
            `LCPM_TLS_GEN2: decode_speed = lcpm_pkg::LCPM_SPD_5G0;
            default: decode_speed = lcpm_pkg::LCPM_SPD_NONE;
        endcase
    endfunction

    wire lcpm_pkg::lcpm_speed_t tls_speed = decode_speed(i_tls);
    wire tls_below_max = (tls_speed != lcpm_pkg::LCPM_SPD_NONE) && (tls_speed < MAX_SPEED);
    wire lcpm_pkg::lcpm_speed_t adv_nxt = (i_downstream && tls_below_max) ? tls_speed : MAX_SPEED;
    wire grant_nxt = i_downshift_req || (i_auto_change_req && !i_autonomous_speed_inhibit);

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_adv_speed <= lcpm_pkg::LCPM_SPD_NONE;
            o_compliance_speed <= lcpm_pkg::LCPM_SPD_NONE;
            o_enter_compliance <= 1'b0;
            o_speed_change_grant <= 1'b0;
            o_pme_fwd <= 1'b0;
        end else begin
            o_adv_speed <= adv_nxt;
            o_compliance_speed <= tls_speed;
            o_enter_compliance <= i_enter_compliance_bit;
            o_speed_change_grant <= grant_nxt;
            o_pme_fwd <= i_pme_msg_in && !i_d3cold;
        end
    end

endmodule

// [hdl/lcpm_regs.sv]
// Overview of operation
// - Downstream ports cap advertised speed at target.
// - Target code 1 is 2.5G, 2 is 5G.
// - Target speed is the compliance mode speed.
// - Speed inhibit allows only reliability downshifts.
// - Legacy mode: speed control fields read zero.
// - Capability identifier reads fixed one.
// - Next link defaults zero upstream, D0 downstream.
// - Version field reads three.
// - Wake clock flag reads zero.
// - Special init flag defaults to zero.
// - Aux current field reads zero.
// - D1 and D2 support read zero.
// - Wake capable states default 0b11001.
// - No wake message forwarding in D3cold.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "lcpm_consts.svh"

module lcpm_regs #(
    parameter int ADDR_W = 12,
    parameter lcpm_pkg::lcpm_speed_t MAX_SPEED = lcpm_pkg::LCPM_SPD_2G5
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_hot_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    input wire logic i_downstream_pin,
    input wire logic i_legacy_pin,
    input wire logic i_cfg_unlock,
    input wire logic i_d3cold,
    input wire logic i_pme_msg_in,
    input wire logic i_auto_change_req,
    input wire logic i_downshift_req,
    output lcpm_pkg::lcpm_speed_t o_adv_speed,
    output lcpm_pkg::lcpm_speed_t o_compliance_speed,
    output logic o_enter_compliance,
    output logic o_speed_change_grant,
    output logic o_pme_fwd
);

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = ADDR_W'({idx, 2'b00});
    endfunction

    function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        is_addr = (a == byte_addr(idx));
    endfunction

    // Pin synchronisers: the value moves once the second and third stage agree.
    logic [2:0] ds_sync_r;
    logic [2:0] lg_sync_r;
    logic ds_r;
    logic legacy_r;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ds_sync_r <= 3'h0;
            lg_sync_r <= 3'h0;
        end else begin
            ds_sync_r <= {ds_sync_r[1:0], i_downstream_pin};
            lg_sync_r <= {lg_sync_r[1:0], i_legacy_pin};
        end
    end

    wire ds_nxt = (ds_sync_r[1] == ds_sync_r[2]) ? ds_sync_r[2] : ds_r;
    wire legacy_nxt = (lg_sync_r[1] == lg_sync_r[2]) ? lg_sync_r[2] : legacy_r;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ds_r <= 1'b0;
            legacy_r <= 1'b0;
        end else begin
            ds_r <= ds_nxt;
            legacy_r <= legacy_nxt;
        end
    end

    // Bus slave: one wait state, answer in the second access cycle.
    lcpm_pkg::lcpm_apb_state_t state_r;
    lcpm_pkg::lcpm_apb_state_t state_nxt;

    wire hit_lcap2 = is_addr(i_paddr, `LCPM_IDX_LINK_CAP2);
    wire hit_lctl2 = is_addr(i_paddr, `LCPM_IDX_LINK_CTL2);
    wire hit_lsts2 = is_addr(i_paddr, `LCPM_IDX_LINK_STS2);
    wire hit_scap2 = is_addr(i_paddr, `LCPM_IDX_SLOT_CAP2);
    wire hit_sctl2 = is_addr(i_paddr, `LCPM_IDX_SLOT_CTL2);
    wire hit_ssts2 = is_addr(i_paddr, `LCPM_IDX_SLOT_STS2);
    wire hit_power_mgmt_capabilities = is_addr(i_paddr, `LCPM_IDX_PM_CAP);
    wire hit_rsvd = hit_lcap2 || hit_lsts2 || hit_scap2 || hit_sctl2 || hit_ssts2;
    wire hit_any = hit_rsvd || hit_lctl2 || hit_power_mgmt_capabilities;
    wire access = i_psel && i_penable;
    wire capture = access && (state_r == lcpm_pkg::LCPM_APB_IDLE);
    wire commit = access && (state_r == lcpm_pkg::LCPM_APB_ANSWER);
    wire wr_fire = commit && i_pwrite;
    wire wr_ctl = wr_fire && hit_lctl2 && i_pstrb[0] && !legacy_r;
    wire wr_pm_nxt = wr_fire && hit_power_mgmt_capabilities && i_pstrb[1] && i_cfg_unlock;
    wire wr_pm_hi = wr_fire && hit_power_mgmt_capabilities && i_cfg_unlock;

    always_comb begin
        case (state_r)
            lcpm_pkg::LCPM_APB_IDLE: state_nxt = capture ? lcpm_pkg::LCPM_APB_ANSWER : lcpm_pkg::LCPM_APB_IDLE;
            lcpm_pkg::LCPM_APB_ANSWER: state_nxt = lcpm_pkg::LCPM_APB_IDLE;
            default: state_nxt = lcpm_pkg::LCPM_APB_IDLE;
        endcase
    end

    // Link control two storage; enter compliance survives hot reset.
    logic [3:0] tls_r;
    logic enter_compliance_bit_r;
    logic autonomous_speed_inhibit_r;

    always_ff @(posedge i_mclk) begin
        if (i_rst || i_hot_rst) begin
            tls_r <= `LCPM_TLS_RST;
            autonomous_speed_inhibit_r <= 1'b0;
        end else if (wr_ctl) begin
            tls_r <= i_pwdata[`LCPM_TLS_MSB:`LCPM_TLS_LSB];
            autonomous_speed_inhibit_r <= i_pwdata[`LCPM_AUTONOMOUS_SPEED_INHIBIT_BIT];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            enter_compliance_bit_r <= 1'b0;
        end else if (wr_ctl) begin
            enter_compliance_bit_r <= i_pwdata[`LCPM_ENTER_COMPLIANCE_BIT_BIT];
        end
    end

    wire [3:0] tls_eff = legacy_r ? 4'h0 : tls_r;
    wire enter_compliance_bit_eff = legacy_r ? 1'b0 : enter_compliance_bit_r;
    wire autonomous_speed_inhibit_eff = legacy_r ? 1'b0 : autonomous_speed_inhibit_r;
    wire [31:0] rd_lctl2 = {26'h0, autonomous_speed_inhibit_eff, enter_compliance_bit_eff, tls_eff};

    // Power management capability loadable fields.
    logic [7:0] nxt_r;
    logic nxt_set_r;
    logic special_init_flag_r;
    logic [4:0] pme_r;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            nxt_r <= `LCPM_NXT_UP;
            nxt_set_r <= 1'b0;
        end else if (wr_pm_nxt) begin
            nxt_r <= i_pwdata[15:8];
            nxt_set_r <= 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            special_init_flag_r <= `LCPM_SPECIAL_INIT_FLAG_RST;
            pme_r <= `LCPM_PME_RST;
        end else begin
            if (wr_pm_hi && i_pstrb[2]) begin
                special_init_flag_r <= i_pwdata[`LCPM_SPECIAL_INIT_FLAG_BIT];
            end
            if (wr_pm_hi && i_pstrb[3]) begin
                pme_r <= i_pwdata[31:`LCPM_PME_LSB];
            end
        end
    end

    wire [7:0] nxt_dflt = ds_r ? `LCPM_NXT_DOWN : `LCPM_NXT_UP;
    wire [7:0] nxt_eff = nxt_set_r ? nxt_r : nxt_dflt;
    wire [31:0] rd_power_mgmt_capabilities = {pme_r, `LCPM_D2_VAL, `LCPM_D1_VAL, `LCPM_AUX_VAL,
                            special_init_flag_r, 1'b0, `LCPM_WAKECLK_VAL, `LCPM_VER_VAL,
                            nxt_eff, `LCPM_CAPABILITY_IDENTIFIER_VAL};
    wire [31:0] rd_mux = hit_lctl2 ? rd_lctl2 : (hit_power_mgmt_capabilities ? rd_power_mgmt_capabilities : 32'h0);

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_r <= lcpm_pkg::LCPM_APB_IDLE;
            o_pready <= 1'b0;
            o_prdata <= 32'h0;
            o_pslverr <= 1'b0;
        end else begin
            state_r <= state_nxt;
            o_pready <= capture;
            o_prdata <= (capture && !i_pwrite) ? rd_mux : 32'h0;
            o_pslverr <= capture && !hit_any;
        end
    end

    lcpm_speed_ctl #(
        .MAX_SPEED(MAX_SPEED)
    ) lcpm_speed_ctl_i (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_downstream(ds_r),
        .i_tls(tls_eff),
        .i_enter_compliance_bit(enter_compliance_bit_eff),
        .i_autonomous_speed_inhibit(autonomous_speed_inhibit_eff),
        .i_d3cold(i_d3cold),
        .i_pme_msg_in(i_pme_msg_in),
        .i_auto_change_req(i_auto_change_req),
        .i_downshift_req(i_downshift_req),
        .o_adv_speed(o_adv_speed),
        .o_compliance_speed(o_compliance_speed),
        .o_enter_compliance(o_enter_compliance),
        .o_speed_change_grant(o_speed_change_grant),
        .o_pme_fwd(o_pme_fwd)
    );

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    sequence s_setup_rd(logic [7:0] idx);
        i_psel && !i_penable && !i_pwrite && is_addr(i_paddr, idx);
    endsequence

    sequence s_access_rd(logic [7:0] idx);
        i_psel && i_penable && !i_pwrite && is_addr(i_paddr, idx) && state_r == lcpm_pkg::LCPM_APB_IDLE;
    endsequence

    sequence s_pm_read;
        s_setup_rd(`LCPM_IDX_PM_CAP) ##1 s_access_rd(`LCPM_IDX_PM_CAP);
    endsequence

    sequence s_rsvd_read;
        s_setup_rd(`LCPM_IDX_LINK_STS2) ##1 s_access_rd(`LCPM_IDX_LINK_STS2);
    endsequence

    AST_ADV_CEILING: assert property (
        ds_r && !legacy_r && tls_r == `LCPM_TLS_GEN1 && $stable(ds_r) |=> o_adv_speed == lcpm_pkg::LCPM_SPD_2G5)
        else $error("Advertised speed exceeds target on downstream port.");

    AST_TLS_DECODE: assert property (
        tls_eff == `LCPM_TLS_GEN2 |=> o_compliance_speed == lcpm_pkg::LCPM_SPD_5G0)
        else $error("Target code two does not decode to 5 Gbps.");

    AST_TLS_RSVD: assert property (
        tls_eff > `LCPM_TLS_GEN2 || tls_eff == 4'h0 |=> o_compliance_speed == lcpm_pkg::LCPM_SPD_NONE)
        else $error("Reserved target code decoded as a speed.");

    AST_COMPLIANCE: assert property (
        wr_ctl && i_pwdata[`LCPM_ENTER_COMPLIANCE_BIT_BIT] ##1 !wr_ctl && !legacy_r |=> o_enter_compliance)
        else $error("Compliance request did not reach the link.");

    AST_ENTER_COMPLIANCE_BIT_STICKY: assert property (
        enter_compliance_bit_r && i_hot_rst && !wr_ctl |=> enter_compliance_bit_r && tls_r == `LCPM_TLS_RST)
        else $error("Hot reset disturbed the sticky compliance bit.");

    AST_SPEED_INHIBIT: assert property (
        autonomous_speed_inhibit_eff && !i_downshift_req |=> !o_speed_change_grant)
        else $error("Autonomous speed change granted while inhibited.");

    AST_LEGACY_ZERO: assert property (
        legacy_r and s_access_rd(`LCPM_IDX_LINK_CTL2) |=> o_pready && o_prdata[5:0] == 6'h0)
        else $error("Speed control fields visible in legacy mode.");

    AST_CAPABILITY_IDENTIFIER: assert property (
        s_pm_read |=> o_pready && !o_pslverr && o_prdata[7:0] == `LCPM_CAPABILITY_IDENTIFIER_VAL)
        else $error("Capability identifier read wrong.");

    AST_NXT_DFLT: assert property (
        s_pm_read ##0 !nxt_set_r |=> o_prdata[15:8] == ($past(ds_r, 1) ? `LCPM_NXT_DOWN : `LCPM_NXT_UP))
        else $error("Next capability link default wrong.");

    AST_VERSION: assert property (
        s_pm_read |=> o_prdata[18:16] == `LCPM_VER_VAL && o_prdata[20:19] == 2'h0)
        else $error("Version or wake clock flag read wrong.");

    AST_SPECIAL_INIT_FLAG_RST: assert property (
        $fell(i_rst) |-> !special_init_flag_r)
        else $error("Special init flag not zero after reset.");

    AST_AUX_D1D2: assert property (
        s_pm_read |=> o_prdata[26:22] == 5'h0)
        else $error("Aux current or D1/D2 support read nonzero.");

    AST_PME_RST: assert property (
        $fell(i_rst) |-> pme_r == `LCPM_PME_RST && rd_power_mgmt_capabilities[31:27] == 5'h19)
        else $error("Wake capable states not at reset default.");

    AST_D3COLD: assert property (
        i_d3cold [*2] |=> !o_pme_fwd)
        else $error("Wake message forwarded in D3cold.");

    AST_RSVD_READ: assert property (
        s_rsvd_read |=> o_pready && !o_pslverr && o_prdata == 32'h0)
        else $error("Reserved register read nonzero.");

    AST_CTL_WRITE: assert property (
        wr_ctl && !i_hot_rst |=> tls_r == $past(i_pwdata[3:0]) && autonomous_speed_inhibit_r == $past(i_pwdata[5]))
        else $error("Link control write did not take effect.");

    AST_ONE_WAIT: assert property (
        capture |=> o_pready ##1 !o_pready)
        else $error("Answer timing not one wait state.");

    AST_SLVERR_UNMAPPED: assert property (
        capture && !hit_any |=> o_pready && o_pslverr && o_prdata == 32'h0)
        else $error("Unmapped access not answered with an error.");

    AST_RSVD_NO_EFFECT: assert property (
        wr_fire && hit_rsvd && !i_hot_rst |=> $stable({tls_r, enter_compliance_bit_r, autonomous_speed_inhibit_r, nxt_r, special_init_flag_r, pme_r}))
        else $error("Write to a reserved register changed state.");

    AST_LEGACY_NO_WRITE: assert property (
        wr_fire && hit_lctl2 && legacy_r && !i_hot_rst |=> $stable({tls_r, enter_compliance_bit_r, autonomous_speed_inhibit_r}))
        else $error("Link control write took effect in legacy mode.");

    AST_PM_LOCKED: assert property (
        wr_fire && hit_power_mgmt_capabilities && !i_cfg_unlock |=> $stable({nxt_set_r, nxt_r, special_init_flag_r, pme_r}))
        else $error("Locked capability fields changed by a write.");

    AST_PM_UNLOCKED: assert property (
        wr_pm_hi && i_pstrb[3] |=> pme_r == $past(i_pwdata[31:27]))
        else $error("Unlocked write did not load the wake capable states.");

    AST_NXT_LOAD: assert property (
        wr_pm_nxt |=> nxt_set_r && nxt_r == $past(i_pwdata[15:8]))
        else $error("Unlocked write did not load the next capability link.");

    AST_ADV_UPSTREAM: assert property (
        !i_rst && !ds_r |=> o_adv_speed == MAX_SPEED)
        else $error("Upstream port does not advertise the full speed.");

    AST_COMP_OFF: assert property (
        !enter_compliance_bit_eff |=> !o_enter_compliance)
        else $error("Compliance entered without the enter compliance bit.");

    AST_PME_PASS: assert property (
        !i_rst && i_pme_msg_in && !i_d3cold |=> o_pme_fwd)
        else $error("Wake message not forwarded outside D3cold.");

    AST_DOWNSHIFT: assert property (
        !i_rst && i_downshift_req |=> o_speed_change_grant)
        else $error("Reliability downshift not granted.");

    AST_IDLE_QUIET: assert property (
        !o_pready |-> o_prdata == 32'h0 && !o_pslverr)
        else $error("Read data or error shown outside the answer cycle.");

    AST_WRITE_NO_DATA: assert property (
        capture && i_pwrite |=> o_prdata == 32'h0)
        else $error("Write answered with read data.");

endmodule

// [dv/lcpm_host.sv]
`timescale 1ns/1ps

module lcpm_host (
    input wire logic i_mclk,
    input wire logic i_pready,
    input wire logic [31:0] i_prdata,
    input wire logic i_pslverr,
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [11:0] o_paddr,
    output logic [31:0] o_pwdata,
    output logic [3:0] o_pstrb
);
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 12'h000;
        o_pwdata = 32'h0;
        o_pstrb = 4'h0;
    end

    // Software places the values that each scenario asks for, then leaves the inverted address and data on the bus.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] rd, output logic er, output logic to);
        int n;
        to = 1'b1;
        rd = 32'h0;
        er = 1'b0;
        @(posedge i_mclk);
        o_psel <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        o_pstrb <= s;
        @(posedge i_mclk);
        o_penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge i_mclk);
            if (i_pready === 1'b1) begin
                rd = i_prdata;
                er = i_pslverr;
                to = 1'b0;
                break;
            end
        end
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        o_paddr <= ~a;
        o_pwdata <= ~d;
    endtask
endmodule

// [dv/lcpm_regs_bench.sv]
`timescale 1ns/1ps

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end

module lcpm_regs_bench;
    localparam logic [11:0] A_LCTL = 12'h1C0;
    localparam logic [11:0] A_PM = 12'h300;
    logic clk = 1'b0, rst = 1'b1, hot = 1'b0, down = 1'b0, leg = 1'b0, unl = 1'b0;
    logic d3 = 1'b0, pmei = 1'b0, autor = 1'b0, dsr = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, ecmp, grant, pmef, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [3:0] pstrb;
    lcpm_pkg::lcpm_speed_t adv, cspd;
    int fail_count = 0, n_compared = 0;
    int target_speed_limit = 0, enter_compliance_bit = 0, autonomous_speed_inhibit = 0, nxt = 0, nset = 0, special_init_flag = 0, pmes = 25;
    logic [31:0] seed = 32'h26;
    logic [11:0] za [7] = '{12'h1B0, 12'h1C8, 12'h1D0, 12'h1E0, 12'h1E8, 12'h0C0, 12'h1B4};

    always #2.5 clk = ~clk;

    lcpm_host lcpm_host_i (.i_mclk(clk), .i_pready(pready), .i_prdata(prdata), .i_pslverr(pslverr),
        .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata),
        .o_pstrb(pstrb));

    lcpm_regs #(.ADDR_W(12), .MAX_SPEED(lcpm_pkg::LCPM_SPD_5G0)) lcpm_regs_i (.i_mclk(clk), .i_rst(rst),
        .i_hot_rst(hot), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .i_downstream_pin(down), .i_legacy_pin(leg), .i_cfg_unlock(unl), .i_d3cold(d3),
        .i_pme_msg_in(pmei), .i_auto_change_req(autor), .i_downshift_req(dsr), .o_adv_speed(adv),
        .o_compliance_speed(cspd), .o_enter_compliance(ecmp), .o_speed_change_grant(grant),
        .o_pme_fwd(pmef));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] e_lctl();
        return leg ? 32'h0 : 32'(target_speed_limit | (enter_compliance_bit << 4) | (autonomous_speed_inhibit << 5));
    endfunction

    function automatic logic [31:0] e_pm();
        logic [7:0] nv;
        nv = nset ? 8'(nxt) : (down ? 8'hD0 : 8'h00);
        return {5'(pmes), 5'h00, 1'(special_init_flag), 2'h0, 3'h3, nv, 8'h01};
    endfunction

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic to;
        lcpm_host_i.xfer(w, a, d, s, rv, rerr, to);
        #1;
        if (to) begin
            fail_count++;
            $display("unexpected pready timeout at %h", a);
            wrap_up();
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    initial begin
        int i;
        logic [31:0] r, s;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        step(5);
        for (i = 0; i < 7; i++) begin
            xf(1'b1, za[i], xs(), 4'hF);
            xf(1'b0, za[i], 32'h0, 4'h0);
            `CHK("reserved", 32'h0, rv)
            `CHK("slverr", (i >= 5), rerr)
        end
        xf(1'b0, A_PM, 32'h0, 4'h0);
        `CHK("pm_cap", e_pm(), rv)
        `CHK("adv_up", 2'h2, adv)
        $display("test reset_values done");
        @(posedge clk) down <= 1'b1;
        step(5);
        xf(1'b0, A_PM, 32'h0, 4'h0);
        `CHK("pm_down", e_pm(), rv)
        for (i = 0; i < 4; i++) begin
            r = xs();
            s = xs();
            r[3:0] = 4'(i);
            xf(1'b1, A_LCTL, r, s[3:0] | 4'h1);
            target_speed_limit = i;
            enter_compliance_bit = r[4];
            autonomous_speed_inhibit = r[5];
            xf(1'b0, A_LCTL, 32'h0, 4'h0);
            `CHK("lctl", e_lctl(), rv)
            `CHK("comp_speed", (i == 1) ? 2'h1 : (i == 2) ? 2'h2 : 2'h0, cspd)
            `CHK("adv_down", (i == 1) ? 2'h1 : 2'h2, adv)
        end
        $display("test target_speed done");
        xf(1'b1, A_LCTL, 32'h31, 4'hF);
        @(posedge clk) hot <= 1'b1;
        @(posedge clk) hot <= 1'b0;
        target_speed_limit = 0;
        enter_compliance_bit = 1;
        autonomous_speed_inhibit = 0;
        step(3);
        xf(1'b0, A_LCTL, 32'h0, 4'h0);
        `CHK("lctl_hot", e_lctl(), rv)
        `CHK("enter_comp", 1'b1, ecmp)
        $display("test compliance done");
        xf(1'b1, A_LCTL, 32'h21, 4'hF);
        @(posedge clk) autor <= 1'b1;
        step(2);
        `CHK("grant_inh", 1'b0, grant)
        @(posedge clk) dsr <= 1'b1;
        step(2);
        `CHK("grant_down", 1'b1, grant)
        @(posedge clk) dsr <= 1'b0;
        xf(1'b1, A_LCTL, 32'h01, 4'hF);
        target_speed_limit = 1;
        enter_compliance_bit = 0;
        autonomous_speed_inhibit = 0;
        step(2);
        `CHK("grant_auto", 1'b1, grant)
        @(posedge clk) autor <= 1'b0;
        $display("test speed_inhibit done");
        @(posedge clk) pmei <= 1'b1;
        step(2);
        `CHK("pme_fwd", 1'b1, pmef)
        @(posedge clk) d3 <= 1'b1;
        step(2);
        `CHK("pme_d3cold", 1'b0, pmef)
        @(posedge clk) pmei <= 1'b0;
        $display("test wake_forward done");
        xf(1'b1, A_PM, xs(), 4'hF);
        xf(1'b0, A_PM, 32'h0, 4'h0);
        `CHK("pm_locked", e_pm(), rv)
        @(posedge clk) unl <= 1'b1;
        r = xs();
        xf(1'b1, A_PM, r, 4'hF);
        nset = 1;
        nxt = r[15:8];
        special_init_flag = r[21];
        pmes = r[31:27];
        @(posedge clk) unl <= 1'b0;
        xf(1'b0, A_PM, 32'h0, 4'h0);
        `CHK("pm_loaded", e_pm(), rv)
        $display("test pm_fields done");
        @(posedge clk) leg <= 1'b1;
        step(5);
        xf(1'b0, A_LCTL, 32'h0, 4'h0);
        `CHK("lctl_legacy", e_lctl(), rv)
        xf(1'b1, A_LCTL, 32'h3F, 4'hF);
        @(posedge clk) leg <= 1'b0;
        step(5);
        xf(1'b0, A_LCTL, 32'h0, 4'h0);
        `CHK("lctl_after", e_lctl(), rv)
        $display("test legacy done");
        wrap_up();
    end
endmodule
